// *** hdl/ait_pkg.sv ***
// Purpose: Shared constants and types for the sequencer interrupt, drop and trigger registers
// Assumes: Four sequencers, 32-bit register port, one clock
// Notes:   Offsets are byte addresses on the plain register port
package ait_pkg;

  // Register byte offsets
  localparam logic [11:0] AIT_OFS_IRQ_ENABLE  = 12'h008;
  localparam logic [11:0] AIT_OFS_MASKED_STAT = 12'h00c;
  localparam logic [11:0] AIT_OFS_DROP_STAT   = 12'h010;
  localparam logic [11:0] AIT_OFS_TRIG_SEL    = 12'h014;
  localparam logic [11:0] AIT_OFS_RAW_STAT    = 12'h004;

  // Reset values
  localparam logic [31:0] AIT_RST_ZERO = 32'h0000_0000;

  // Field geometry of the trigger select register
  localparam int AIT_NUM_SEQ    = 4;
  localparam int AIT_CODE_W     = 4;

  // Trigger source codes
  localparam logic [3:0] AIT_TRIG_PROC   = 4'h0;
  localparam logic [3:0] AIT_TRIG_COMP0  = 4'h1;
  localparam logic [3:0] AIT_TRIG_PIN    = 4'h4;
  localparam logic [3:0] AIT_TRIG_TIMER  = 4'h5;
  localparam logic [3:0] AIT_TRIG_PWM_A  = 4'h6;
  localparam logic [3:0] AIT_TRIG_PWM_B  = 4'h7;
  localparam logic [3:0] AIT_TRIG_PWM_C  = 4'h8;
  localparam logic [3:0] AIT_TRIG_ALWAYS = 4'hf;

  // Event sources that can start a sequence
  typedef struct packed {
    logic proc;      // Software initiate, per sequencer bit handled outside
    logic comp0;     // Analogue comparator 0
    logic ext_pin;   // External trigger pin
    logic timer;     // Timer event
    logic pwm_a;     // PWM generator 0
    logic pwm_b;     // PWM generator 1
    logic pwm_c;     // PWM generator 2
  } ait_events_s;

  // Register port request
  typedef struct packed {
    logic        wr;    // Write strobe
    logic        rd;    // Read strobe
    logic [11:0] addr;  // Byte address
    logic [31:0] wdata; // Write data
  } ait_bus_req_s;

endpackage : ait_pkg

// *** hdl/ait_regs.sv ***
// Purpose: Interrupt mask, masked status, FIFO drop flags and trigger selection
// Assumes: Event and conversion inputs come from logic on i_sys_clk, except the pin
// Notes:   Read data appear the cycle after the read strobe and only then
//
// Behaviour
// - Forward raw interrupt only while enable set
// - Masked status reads raw AND enable
// - Write one clears masked and raw flag
// - Clear works even when enable is zero
// - Controller interrupt is a held level
// - Full FIFO write drops data, sets flag
// - Drop flag stays until written one
// - Four 4-bit trigger fields, seq0 lowest
// - Code 0 processor, code 1 comparator
// - Codes 4-8 pin, timer, PWM 0-2
// - Code 15 samples continuously
// - All fields decode alike, independently
// - Interrupt-marked sample completion sets raw flag
`timescale 1ns/10ps
`default_nettype none

module ait_regs
  import ait_pkg::*;
#(
  parameter int NUM_SEQ = AIT_NUM_SEQ  // Number of sample sequencers
) (
  input  wire logic               i_sys_clk,      // System clock, 200 MHz
  input  wire logic               i_srst,         // Synchronous reset, active high
  input  wire ait_bus_req_s       i_bus,          // Register port request
  output logic [31:0]             o_rdata,        // Read data, cycle after read
  input  wire ait_events_s        i_events,       // Trigger events, pin unsynchronised
  input  wire logic [NUM_SEQ-1:0] i_proc_start,   // Software initiate per sequencer
  input  wire logic [NUM_SEQ-1:0] i_conv_done,    // Sample conversion finished
  input  wire logic [NUM_SEQ-1:0] i_step_irq_request, // That sample asks for interrupt
  input  wire logic [NUM_SEQ-1:0] i_fifo_full,    // Result FIFO full
  input  wire logic [NUM_SEQ-1:0] i_fifo_wr_req,  // Result arriving for FIFO
  output logic [NUM_SEQ-1:0]      o_fifo_wr,      // Write accepted into FIFO
  output logic [NUM_SEQ-1:0]      o_seq_trigger,  // Start sampling, one per sequencer
  output logic [NUM_SEQ-1:0]      o_ctrl_irq      // Level interrupt to controller
);

  // Field width fixed by layout; the register holds four codes in 16 bits
  initial begin
    if (NUM_SEQ != AIT_NUM_SEQ) begin
      $error("ait_regs supports exactly four sequencers");
    end
  end

  // Storage
  logic [NUM_SEQ-1:0]            irq_enable_reg;        // Mask bits
  logic [NUM_SEQ-1:0]            raw_irq_status;        // Raw interrupt flags
  logic [NUM_SEQ-1:0]            fifo_drop_status;      // Overflow flags
  logic [NUM_SEQ*AIT_CODE_W-1:0] trigger_source_select; // Packed trigger codes
  logic                          pin_meta;              // Pin sync stage one
  logic                          pin_sync;              // Pin sync stage two

  // Address decode
  wire hit_en   = (i_bus.addr == AIT_OFS_IRQ_ENABLE);
  wire hit_msk  = (i_bus.addr == AIT_OFS_MASKED_STAT);
  wire hit_drop = (i_bus.addr == AIT_OFS_DROP_STAT);
  wire hit_trig = (i_bus.addr == AIT_OFS_TRIG_SEL);
  wire hit_raw  = (i_bus.addr == AIT_OFS_RAW_STAT);

  // Write-one-to-clear masks; a zero bit leaves the flag alone
  wire [NUM_SEQ-1:0] clr_raw  = (i_bus.wr && hit_msk)  ? i_bus.wdata[NUM_SEQ-1:0]
                                                       : '0;
  wire [NUM_SEQ-1:0] clr_drop = (i_bus.wr && hit_drop) ? i_bus.wdata[NUM_SEQ-1:0]
                                                       : '0;

  // Hardware set terms
  wire [NUM_SEQ-1:0] set_raw  = i_conv_done & i_step_irq_request;
  wire [NUM_SEQ-1:0] set_drop = i_fifo_wr_req & i_fifo_full;

  // Set wins over a simultaneous clear
  wire [NUM_SEQ-1:0] next_raw  = (raw_irq_status & ~clr_raw) | set_raw;
  wire [NUM_SEQ-1:0] next_drop = (fifo_drop_status & ~clr_drop) | set_drop;

  // Masked status is the AND of raw and enable
  wire [NUM_SEQ-1:0] masked_irq = raw_irq_status & irq_enable_reg;

  // Next-cycle interrupt level built from next raw and next enable
  wire [NUM_SEQ-1:0] next_en = (i_bus.wr && hit_en) ? i_bus.wdata[NUM_SEQ-1:0]
                                                    : irq_enable_reg;
  wire [NUM_SEQ-1:0] next_irq = next_raw & next_en;

  // Read mux; unused upper bits read as zero
  wire [31:0] rd_mux =
      hit_en   ? {{(32-NUM_SEQ){1'b0}}, irq_enable_reg}   :
      hit_msk  ? {{(32-NUM_SEQ){1'b0}}, masked_irq}       :
      hit_drop ? {{(32-NUM_SEQ){1'b0}}, fifo_drop_status} :
      hit_trig ? {16'h0000, trigger_source_select}        :
      hit_raw  ? {{(32-NUM_SEQ){1'b0}}, raw_irq_status}   :
                 AIT_RST_ZERO;                             // Unmapped reads zero

  // Trigger decode, one identical decoder per sequencer field
  logic [NUM_SEQ-1:0] next_trig;
  genvar g;
  generate
    for (g = 0; g < NUM_SEQ; g++) begin : g_seq
      wire [AIT_CODE_W-1:0] code =
          trigger_source_select[g*AIT_CODE_W +: AIT_CODE_W];
      // Reserved codes select nothing, so the sequencer stays idle
      assign next_trig[g] =
          (code == AIT_TRIG_PROC)   ? i_proc_start[g]  :
          (code == AIT_TRIG_COMP0)  ? i_events.comp0   :
          (code == AIT_TRIG_PIN)    ? pin_sync         :
          (code == AIT_TRIG_TIMER)  ? i_events.timer   :
          (code == AIT_TRIG_PWM_A)  ? i_events.pwm_a   :
          (code == AIT_TRIG_PWM_B)  ? i_events.pwm_b   :
          (code == AIT_TRIG_PWM_C)  ? i_events.pwm_c   :
          (code == AIT_TRIG_ALWAYS) ? 1'b1             : 1'b0;
    end
  endgenerate

  // Pin synchroniser; stage one feeds only stage two
  always_ff @(posedge i_sys_clk) begin
    pin_meta <= i_events.ext_pin;
    pin_sync <= pin_meta;
  end

  // Control registers written by software
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      irq_enable_reg        <= '0;
      trigger_source_select <= '0;
    end else begin
      if (i_bus.wr && hit_en) begin
        irq_enable_reg <= i_bus.wdata[NUM_SEQ-1:0];
      end
      if (i_bus.wr && hit_trig) begin
        trigger_source_select <= i_bus.wdata[NUM_SEQ*AIT_CODE_W-1:0];
      end
    end
  end

  // Status flags set by hardware, cleared by software
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      raw_irq_status   <= '0;
      fifo_drop_status <= '0;
    end else begin
      raw_irq_status   <= next_raw;
      fifo_drop_status <= next_drop;
    end
  end

  // Registered outputs
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_rdata       <= AIT_RST_ZERO;
      o_ctrl_irq    <= '0;
      o_seq_trigger <= '0;
    end else begin
      o_rdata       <= i_bus.rd ? rd_mux : AIT_RST_ZERO;
      o_ctrl_irq    <= next_irq;
      o_seq_trigger <= next_trig;
    end
  end

  // FIFO write pass, registered; a full FIFO loses the newest result
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_fifo_wr <= '0;
    end else begin
      o_fifo_wr <= i_fifo_wr_req & ~i_fifo_full;
    end
  end

endmodule : ait_regs

`default_nettype wire

// *** tb/ait_regs_assertions.sv ***
// Purpose: port checks for ait_regs. Assumes: one clock. Notes: bound at the foot.
`timescale 1ns/10ps
`default_nettype none
module ait_regs_chk
  import ait_pkg::*;
(
  input wire logic         i_sys_clk,
  input wire logic         i_srst,
  input wire ait_bus_req_s i_bus,
  input wire ait_events_s  i_events,
  input wire logic [3:0]   i_conv_done,
  input wire logic [3:0]   i_step_irq_request,
  input wire logic [3:0]   i_fifo_full,
  input wire logic [3:0]   i_fifo_wr_req,
  input wire logic [31:0]  o_rdata,
  input wire logic [3:0]   o_fifo_wr,
  input wire logic [3:0]   o_seq_trigger,
  input wire logic [3:0]   o_ctrl_irq
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);
  // Decoded strobes, so the properties stay short
  wire        w_en = i_bus.wr && i_bus.addr == AIT_OFS_IRQ_ENABLE;
  wire        w_ms = i_bus.wr && i_bus.addr == AIT_OFS_MASKED_STAT;
  wire        w_ts = i_bus.wr && i_bus.addr == AIT_OFS_TRIG_SEL;
  wire        r_ts = i_bus.rd && i_bus.addr == AIT_OFS_TRIG_SEL;
  wire        setp = |(i_conv_done & i_step_irq_request);
  wire [3:0]  acc  = i_fifo_wr_req & ~i_fifo_full;
  wire [15:0] wlo  = i_bus.wdata[15:0];
  property p_mask; w_en && i_bus.wdata[3:0] == 4'h0 |=> o_ctrl_irq == 4'h0; endproperty
  a_mask: assert property (p_mask) else $error("irq passed while masked");
  property p_clr; w_ms && i_bus.wdata[3:0] == 4'hf && !setp |=> o_ctrl_irq == 4'h0; endproperty
  a_clr: assert property (p_clr) else $error("irq not cleared");
  property p_lvl; o_ctrl_irq[0] && !(w_en || w_ms) |=> o_ctrl_irq[0]; endproperty
  a_lvl: assert property (p_lvl) else $error("irq level dropped");
  property p_keep; o_ctrl_irq[2] && w_ms && !i_bus.wdata[2] |=> o_ctrl_irq[2]; endproperty
  a_keep: assert property (p_keep) else $error("zero write cleared irq");
  property p_drop; i_fifo_wr_req != 4'h0 |=> o_fifo_wr == $past(acc); endproperty
  a_drop: assert property (p_drop) else $error("fifo write pass wrong");
  property p_tim; w_ts && wlo == 16'h5555 ##1 !i_bus.wr |=> o_seq_trigger == {4{$past(i_events.timer)}}; endproperty
  a_tim: assert property (p_tim) else $error("timer trigger wrong");
  property p_all; w_ts && wlo == 16'hffff |=> ##1 o_seq_trigger == 4'hf; endproperty
  a_all: assert property (p_all) else $error("continuous trigger missing");
  property p_fld; w_ts ##2 r_ts |=> o_rdata == {16'h0, $past(wlo, 3)}; endproperty
  a_fld: assert property (p_fld) else $error("trigger fields read wrong");
endmodule // ait_regs_chk
bind ait_regs ait_regs_chk u_ait_regs_chk (.i_sys_clk(i_sys_clk), .i_srst(i_srst),
  .i_bus(i_bus), .i_events(i_events), .i_conv_done(i_conv_done),
  .i_step_irq_request(i_step_irq_request), .i_fifo_full(i_fifo_full),
  .i_fifo_wr_req(i_fifo_wr_req), .o_rdata(o_rdata), .o_fifo_wr(o_fifo_wr),
  .o_seq_trigger(o_seq_trigger), .o_ctrl_irq(o_ctrl_irq));
`default_nettype wire

// *** tb/ait_irq_ctl_model.sv ***
// Purpose: interrupt controller model. Assumes: one clock. Notes: remembers levels seen.
`timescale 1ns/10ps
`default_nettype none
module ait_irq_ctl_model (
  input  wire logic       i_sys_clk,
  input  wire logic       i_srst,
  input  wire logic [3:0] i_irq,
  output logic [3:0]      o_seen
);
  // Lines are level sensed each cycle and kept until reset
  always_ff @(posedge i_sys_clk) o_seen <= i_srst ? 4'h0 : (o_seen | i_irq);
endmodule // ait_irq_ctl_model
`default_nettype wire

// *** tb/adc_irq_overflow_trigger_regs_test.sv ***
// Purpose: self-checking bench. Assumes: 200 MHz clock. Notes: table loop, then cases.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected t=%0t got %h exp %h", $time, g, e); end end
module adc_irq_overflow_trigger_regs_test
  import ait_pkg::*;
;
  typedef struct {logic [11:0] a; logic [31:0] w; logic [31:0] e;} ait_row_s;
  logic         clk = 1'b0, srst = 1'b1;
  ait_bus_req_s bus = '0;
  ait_events_s  ev = '0;
  logic [3:0]   pst = '0, done = '0, ireq = '0, full = '0, wreq = '0, fwr, trig, irq, seen;
  logic [31:0]  rdata;
  int           n_fail = 0, checked = 0, cyc = 0;
  // Writes then readbacks; status and unmapped places must read zero
  ait_row_s rows[6] = '{'{12'h008, 32'hf, 32'hf}, '{12'h00c, 32'hf, 32'h0},
    '{12'h010, 32'hf, 32'h0}, '{12'h004, 32'hf, 32'h0}, '{12'h018, 32'hf, 32'h0},
    '{12'h014, 32'h8765, 32'h8765}};
  // Only defined codes are ever written; upper bits always written as zero
  logic [3:0] codes[8] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'hf};
  logic [6:0] srcs[8] = '{7'h00, 7'h20, 7'h10, 7'h08, 7'h04, 7'h02, 7'h01, 7'h00};
  always #2.5 clk = ~clk;
  ait_regs u_ait_regs (.i_sys_clk(clk), .i_srst(srst), .i_bus(bus), .o_rdata(rdata),
    .i_events(ev), .i_proc_start(pst), .i_conv_done(done), .i_step_irq_request(ireq),
    .i_fifo_full(full), .i_fifo_wr_req(wreq), .o_fifo_wr(fwr), .o_seq_trigger(trig),
    .o_ctrl_irq(irq));
  ait_irq_ctl_model u_ait_irq_ctl_model (.i_sys_clk(clk), .i_srst(srst), .i_irq(irq),
    .o_seen(seen));
  // Bus cycles; an idle edge after each keeps strobes from being driven twice at once
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus <= '{1'b1, 1'b0, a, d};
    @(posedge clk) bus <= '0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    bus <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge clk) bus <= '0;
    @(posedge clk) `CHK(rdata, e)
  endtask
  task automatic close_out;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Hang guard, well above the roughly 180 cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin n_fail++; close_out; end
  end
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    foreach (rows[i]) begin
      rd(rows[i].a, 32'h0);
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, rows[i].e);
    end
    $display("register table done");
    wr(12'h008, 32'h5);
    done <= 4'hf; ireq <= 4'hf;
    @(posedge clk) begin done <= 4'h0; ireq <= 4'h0; end
    @(posedge clk) `CHK(irq, 4'h5)
    rd(12'h004, 32'hf);
    rd(12'h00c, 32'h5);
    `CHK(seen, 4'h5)
    wr(12'h00c, 32'h2);
    wr(12'h00c, 32'h0);
    rd(12'h004, 32'hd);
    // Clear and a new set land on the same edge; the set must survive
    bus <= '{1'b1, 1'b0, 12'h00c, 32'h4}; done <= 4'h4; ireq <= 4'h4;
    @(posedge clk) begin bus <= '0; done <= 4'h0; ireq <= 4'h0; end
    @(posedge clk) rd(12'h004, 32'hd);
    wr(12'h00c, 32'h1);
    `CHK(irq, 4'h4)
    wr(12'h008, 32'h0);
    `CHK(irq, 4'h0)
    $display("interrupt cases done");
    full <= 4'h1; wreq <= 4'h3; done <= 4'h2;
    @(posedge clk) begin full <= 4'h0; wreq <= 4'h0; done <= 4'h0; end
    @(posedge clk) `CHK(fwr, 4'h2)
    rd(12'h004, 32'hc);
    rd(12'h010, 32'h1);
    rd(12'h010, 32'h1);
    wr(12'h010, 32'h1);
    rd(12'h010, 32'h0);
    // Each defined code: other sources busy must not start it, its own source must; code 15 starts it either way
    foreach (codes[k]) begin
      wr(12'h014, {16'h0, {4{codes[k]}}});
      for (int on = 0; on < 2; on++) begin
        ev <= (on == 1) ? srcs[k] : (~srcs[k] & 7'h3f);
        pst <= ((codes[k] == 4'h0) == (on == 1)) ? 4'hf : 4'h0;
        repeat (5) @(posedge clk);
        `CHK(trig, (on == 1 || codes[k] == 4'hf) ? 4'hf : 4'h0)
      end
    end
    wr(12'h014, 32'h0f51);
    ev <= 7'h08; pst <= 4'h0;
    repeat (5) @(posedge clk);
    `CHK(trig, 4'h6)
    $display("trigger cases done");
    wr(12'h008, 32'hf);
    srst <= 1'b1;
    @(posedge clk) srst <= 1'b0;
    @(posedge clk) rd(12'h008, 32'h0);
    `CHK(irq, 4'h0)
    `CHK(trig, 4'h0)
    close_out;
  end
endmodule // adc_irq_overflow_trigger_regs_test
`default_nettype wire
